/* design/swtm_consts.vh */
// constants for the scan watchdog and timing monitor
`ifndef SWTM_CONSTS_VH
`define SWTM_CONSTS_VH

`define SWTM_CLK_HZ            50000000
`define SWTM_CLK_NS            20
// watchdog default limit, in ms and in 1 ms ticks
`define SWTM_WD_DEFAULT_MS     16'd200
`define SWTM_TICK_CYCLES       (`SWTM_CLK_HZ / 1000)
// initialization time, in ms (1.2 s to 3.7 s)
`define SWTM_INIT_MIN_MS       1200
`define SWTM_INIT_MAX_MS       3700
// input-read cost, in ns
`define SWTM_RD_OVH_NS         12600
`define SWTM_RD_PT_NS          2500
// specialty read cost, in ns
`define SWTM_SP_OVH_NS         1820
`define SWTM_SP_MOD_NS         17900
`define SWTM_SP_PT_NS          2000
// peripheral service bounds, in ns
`define SWTM_PS_MIN_NS         8000
`define SWTM_PS_MAX_NS         410000
// error codes
`define SWTM_ERR_NONE          8'h00
`define SWTM_ERR_OVERRUN       8'h03
`define SWTM_ERR_BUS_TIMEOUT   8'h04
`define SWTM_ERR_PERIPH_OVER   8'h05
// bus segment timeout, in ticks
`define SWTM_BUS_LIMIT_MS      16'd100

`endif

/* design/swtm_seg_timer.v */
// segment duration timer: counts down a cycle budget and flags done
`include "swtm_consts.vh"

module swtm_seg_timer (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        load,
  input  wire [23:0] cycles,
  output reg         busy,
  output wire        done
);

  reg [23:0] remain;

  assign done = busy && (remain == 24'h000001);

  always @(posedge clk_sys) begin
    if (srst) begin
      busy   <= 1'b0;
      remain <= 24'h000000;
    end else if (load) begin
      busy   <= (cycles != 24'h000000);
      remain <= cycles;
    end else if (busy) begin
      remain <= remain - 24'h000001;
      if (remain == 24'h000001) begin
        busy <= 1'b0;
      end
    end
  end

endmodule // swtm_seg_timer

/* design/swtm_scan_watchdog.v */
// scan sequencer, watchdog and scan-time statistics
`include "swtm_consts.vh"

module swtm_scan_watchdog #(
  parameter INIT_MS = `SWTM_INIT_MIN_MS
) (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        run_request,
  input  wire        wd_limit_load,
  input  wire [15:0] wd_limit_value,
  input  wire        watchdog_restart_instruction,
  input  wire        solve_end,
  input  wire [7:0]  input_points,
  input  wire [3:0]  special_modules,
  input  wire [7:0]  special_points,
  input  wire        periph_connected,
  input  wire        periph_request,
  input  wire        periph_done,
  input  wire        bus_pending,
  input  wire [15:0] input_pins,
  input  wire        imm_read,
  input  wire [3:0]  imm_index,
  input  wire [15:0] solve_outputs,
  output reg         run_mode,
  output reg         init_done,
  output reg  [2:0]  segment,
  output reg  [15:0] input_image,
  output reg  [15:0] output_pins,
  output reg         imm_bit,
  output reg         periph_grant,
  output reg         bus_grant,
  output reg  [15:0] wd_limit,
  output reg  [15:0] wd_count,
  output reg  [15:0] scan_cur,
  output reg  [15:0] scan_min,
  output reg  [15:0] scan_max,
  output reg         scan_overrun_error,
  output reg  [7:0]  error_code,
  output reg         status_first_scan
);

  // ==========================================================
  // segments
  localparam SEG_INIT   = 3'd0;
  localparam SEG_READ   = 3'd1;
  localparam SEG_SPEC   = 3'd2;
  localparam SEG_PERIPH = 3'd3;
  localparam SEG_BUS    = 3'd4;
  localparam SEG_DIAG   = 3'd5;
  localparam SEG_SOLVE  = 3'd6;
  localparam SEG_WRITE  = 3'd7;

  localparam [31:0] TICK_W    = `SWTM_TICK_CYCLES;
  localparam [31:0] PS_MIN_W  = (`SWTM_PS_MIN_NS + `SWTM_CLK_NS - 1) / `SWTM_CLK_NS;
  localparam [31:0] PS_MAX_W  = `SWTM_PS_MAX_NS / `SWTM_CLK_NS;
  localparam [23:0] TICK_CYC  = TICK_W[23:0];
  localparam [23:0] PS_MIN    = PS_MIN_W[23:0];
  localparam [23:0] PS_MAX    = PS_MAX_W[23:0];
  localparam [31:0] INIT_CYC  = INIT_MS * (`SWTM_CLK_HZ / 1000);

  // ==========================================================
  // cycle-count helpers
  function [23:0] ns_to_cyc;
    input [31:0] ns;
    begin
      ns_to_cyc = ns_to_cyc_w(ns);
    end
  endfunction

  function [23:0] ns_to_cyc_w;
    input [31:0] ns;
    reg   [31:0] c;
    begin
      c = (ns + `SWTM_CLK_NS - 1) / `SWTM_CLK_NS;
      ns_to_cyc_w = (c == 32'd0) ? 24'd1 : c[23:0];
    end
  endfunction

  // ==========================================================
  // time base: 1 ms tick
  reg [23:0] tick_cnt;
  wire       tick = (tick_cnt == TICK_CYC - 24'd1);

  always @(posedge clk_sys) begin
    if (srst || tick) begin
      tick_cnt <= 24'd0;
    end else begin
      tick_cnt <= tick_cnt + 24'd1;
    end
  end

  // ==========================================================
  // segment timer
  reg        seg_load;
  reg [23:0] seg_cycles;
  wire       seg_busy;
  wire       seg_done;

  swtm_seg_timer u_seg (
    .clk_sys (clk_sys),
    .srst    (srst),
    .load    (seg_load),
    .cycles  (seg_cycles),
    .busy    (seg_busy),
    .done    (seg_done)
  );

  // ==========================================================
  // peripheral request log
  reg        periph_logged;
  reg [23:0] ps_cnt;
  reg        run_q;
  reg [31:0] init_cnt;
  reg [15:0] scan_ms;
  reg        stats_valid;
  reg        seg_started;
  reg [15:0] bus_ms;

  always @(posedge clk_sys) begin
    if (srst) begin
      periph_logged <= 1'b0;
    end else if (periph_request && periph_connected) begin
      periph_logged <= 1'b1;
    end else if (segment == SEG_PERIPH && periph_done && ps_cnt >= PS_MIN) begin
      periph_logged <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  always @* begin
    seg_load   = 1'b0;
    seg_cycles = 24'd0;
    if (!seg_started) begin
      case (segment)
        SEG_READ: begin
          seg_load   = 1'b1;
          seg_cycles = ns_to_cyc(`SWTM_RD_OVH_NS + `SWTM_RD_PT_NS * {24'd0, input_points});
        end
        SEG_SPEC: begin
          seg_load   = 1'b1;
          seg_cycles = ns_to_cyc(`SWTM_SP_OVH_NS
                       + `SWTM_SP_MOD_NS * {28'd0, special_modules}
                       + `SWTM_SP_PT_NS * {24'd0, special_points});
        end
        default: begin
          seg_load   = 1'b0;
          seg_cycles = 24'd0;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      segment            <= SEG_INIT;
      init_done          <= 1'b0;
      init_cnt           <= 32'd0;
      seg_started        <= 1'b0;
      run_mode           <= 1'b0;
      run_q              <= 1'b0;
      input_image        <= 16'h0000;
      output_pins        <= 16'h0000;
      periph_grant       <= 1'b0;
      bus_grant          <= 1'b0;
      ps_cnt             <= 24'd0;
      bus_ms             <= 16'h0000;
      wd_limit           <= `SWTM_WD_DEFAULT_MS;
      wd_count           <= 16'h0000;
      scan_ms            <= 16'h0000;
      scan_cur           <= 16'h0000;
      scan_min           <= 16'hffff;
      scan_max           <= 16'h0000;
      stats_valid        <= 1'b0;
      scan_overrun_error <= 1'b0;
      error_code         <= `SWTM_ERR_NONE;
      status_first_scan  <= 1'b0;
    end else begin
      run_q <= run_mode;
      if (wd_limit_load && wd_limit_value != 16'h0000) begin
        wd_limit <= wd_limit_value;
      end
      if (run_request && !run_mode && init_done && !scan_overrun_error) begin
        run_mode <= 1'b1;
      end else if (!run_request) begin
        run_mode <= 1'b0;
      end
      if (run_mode && !run_q) begin
        scan_min    <= 16'hffff;
        scan_max    <= 16'h0000;
        scan_cur    <= 16'h0000;
        stats_valid <= 1'b0;
      end
      if (init_done && tick) begin
        scan_ms <= scan_ms + 16'h0001;
      end
      case (segment)
        SEG_INIT: begin
          if (init_cnt == INIT_CYC - 32'd1) begin
            init_done <= 1'b1;
            segment   <= SEG_READ;
            scan_ms   <= 16'h0000;
          end else begin
            init_cnt <= init_cnt + 32'd1;
          end
        end
        // inputs sampled once per scan here
        SEG_READ: begin
          seg_started <= 1'b1;
          if (seg_done) begin
            input_image <= input_pins;
            seg_started <= 1'b0;
            segment     <= SEG_SPEC;
          end
        end
        SEG_SPEC: begin
          seg_started <= 1'b1;
          if (seg_done) begin
            seg_started <= 1'b0;
            segment     <= SEG_PERIPH;
            ps_cnt      <= 24'd0;
          end
        end
        SEG_PERIPH: begin
          if (!periph_logged || !periph_connected) begin
            periph_grant <= 1'b0;
            segment      <= SEG_BUS;
          end else begin
            periph_grant <= 1'b1;
            ps_cnt       <= ps_cnt + 24'd1;
            if (run_mode && ps_cnt >= PS_MAX) begin
              error_code   <= `SWTM_ERR_PERIPH_OVER;
              periph_grant <= 1'b0;
              segment      <= SEG_BUS;
            end else if (periph_done && ps_cnt >= PS_MIN) begin
              periph_grant <= 1'b0;
              segment      <= SEG_BUS;
            end
          end
        end
        SEG_BUS: begin
          bus_grant <= bus_pending;
          if (tick) begin
            bus_ms <= bus_ms + 16'h0001;
          end
          if (!bus_pending) begin
            bus_grant <= 1'b0;
            bus_ms    <= 16'h0000;
            segment   <= SEG_DIAG;
          end else if (bus_ms >= `SWTM_BUS_LIMIT_MS) begin
            error_code <= `SWTM_ERR_BUS_TIMEOUT;
          end
        end
        SEG_DIAG: begin
          scan_cur          <= scan_ms;
          status_first_scan <= run_mode && !stats_valid;
          if (run_mode) begin
            stats_valid <= 1'b1;
            if (scan_ms < scan_min) begin
              scan_min <= scan_ms;
            end
            if (scan_ms > scan_max) begin
              scan_max <= scan_ms;
            end
          end
          scan_ms  <= 16'h0000;
          wd_count <= 16'h0000;
          segment  <= run_mode ? SEG_SOLVE : SEG_WRITE;
        end
        SEG_SOLVE: begin
          // count from zero, compare per tick
          if (watchdog_restart_instruction) begin
            wd_count <= 16'h0000;
          end else if (tick) begin
            wd_count <= wd_count + 16'h0001;
          end
          if (tick && !watchdog_restart_instruction && wd_count + 16'h0001 >= wd_limit) begin
            scan_overrun_error <= 1'b1;
            error_code         <= `SWTM_ERR_OVERRUN;
            run_mode           <= 1'b0;
            output_pins        <= 16'h0000;
            segment            <= SEG_READ;
          end else if (solve_end || !run_mode) begin
            segment <= SEG_WRITE;
          end
        end
        SEG_WRITE: begin
          output_pins <= (run_mode && !scan_overrun_error) ? solve_outputs : 16'h0000;
          segment     <= SEG_READ;
        end
        default: begin
          segment <= SEG_READ;
        end
      endcase
      // overrun error cleared while the run request is low
      if (scan_overrun_error && !run_request) begin
        scan_overrun_error <= 1'b0;
      end
    end
  end

  // ==========================================================
  // immediate read straight from pins
  always @(posedge clk_sys) begin
    if (srst) begin
      imm_bit <= 1'b0;
    end else if (imm_read) begin
      imm_bit <= input_pins[imm_index];
    end
  end

endmodule // swtm_scan_watchdog

/* test/swtm_monitor.sv */
// ==========================================
// assertion checker for the scan watchdog
module swtm_monitor (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        wd_limit_load,
  input wire logic [15:0] wd_limit_value,
  input wire logic        watchdog_restart_instruction,
  input wire logic        periph_connected,
  input wire logic        bus_pending,
  input wire logic [15:0] input_pins,
  input wire logic        imm_read,
  input wire logic [3:0]  imm_index,
  input wire logic        run_mode,
  input wire logic        init_done,
  input wire logic [2:0]  segment,
  input wire logic [15:0] input_image,
  input wire logic [15:0] output_pins,
  input wire logic        imm_bit,
  input wire logic        periph_grant,
  input wire logic [15:0] wd_limit,
  input wire logic [15:0] wd_count,
  input wire logic        scan_overrun_error,
  input wire logic [7:0]  error_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic imm_exp;
  always @(posedge clk_sys) imm_exp <= input_pins[imm_index];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_imm; imm_read |=> imm_bit == imm_exp; endproperty
  a_imm: assert property (p_imm) else $error("immediate bit differs from pin");
  property p_noimg; imm_read && segment != 3'd1 |=> $stable(input_image); endproperty
  a_noimg: assert property (p_noimg) else $error("image moved on immediate read");
  property p_ovr;
    $rose(scan_overrun_error) |-> error_code == 8'h03 && output_pins == 16'h0 && !run_mode;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun reaction incomplete");
  property p_src; $rose(scan_overrun_error) |-> $past(segment) == 3'd6; endproperty
  a_src: assert property (p_src) else $error("overrun outside solve");
  property p_wd; segment == 3'd6 |-> wd_count < wd_limit; endproperty
  a_wd: assert property (p_wd) else $error("watchdog count at limit");
  property p_rst; segment == 3'd6 && watchdog_restart_instruction |=> wd_count == 16'h0; endproperty
  a_rst: assert property (p_rst) else $error("restart ignored");
  property p_solve; segment == 3'd6 |-> run_mode; endproperty
  a_solve: assert property (p_solve) else $error("solve outside run");
  property p_per; !periph_connected |-> !periph_grant; endproperty
  a_per: assert property (p_per) else $error("service with nothing attached");
  property p_init; !init_done |-> segment == 3'd0; endproperty
  a_init: assert property (p_init) else $error("scan before init");
  property p_lim; wd_limit_load && wd_limit_value != 16'h0 |=> wd_limit == $past(wd_limit_value);
  endproperty
  a_lim: assert property (p_lim) else $error("limit not loaded");
  property p_bus; segment == 3'd4 && bus_pending |=> segment == 3'd4; endproperty
  a_bus: assert property (p_bus) else $error("bus left with work pending");
endmodule // swtm_monitor

bind swtm_scan_watchdog swtm_monitor u_mon (.clk_sys, .srst, .wd_limit_load, .wd_limit_value,
  .watchdog_restart_instruction, .periph_connected, .bus_pending, .input_pins, .imm_read,
  .imm_index, .run_mode, .init_done, .segment, .input_image, .output_pins, .imm_bit,
  .periph_grant, .wd_limit, .wd_count, .scan_overrun_error, .error_code);

/* test/swtm_exec_model.sv */
// ==========================================
// scan executive and backplane module model
module swtm_exec_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        hang,
  input  wire logic [2:0]  segment,
  input  wire logic        bus_grant,
  input  wire logic        periph_grant,
  output logic             solve_end = 1'b0,
  output logic             bus_pending = 1'b0,
  output logic             periph_connected,
  output logic             periph_request = 1'b0,
  output logic             periph_done = 1'b0,
  output logic [15:0]      solve_outputs = 16'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  assign periph_connected = ~hang;
  always @(posedge clk_sys) begin
    n <= (!srst && (segment == 3'd6 || bus_grant || periph_grant)) ? n + 1 : 0;
    // reply after a while of service
    periph_done <= periph_grant && n == 450;
    periph_request <= !srst && !periph_request;
    bus_pending <= !srst && (segment != 3'd4 || (bus_pending && n < 4));
    solve_end <= !hang && segment == 3'd6 && n == 40;
    solve_outputs <= solve_outputs + 16'h1;
  end
endmodule // swtm_exec_model

/* test/tb.sv */
// ==========================================
// self-checking bench for the scan watchdog
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, srst = 1'b1, run_request = 1'b0, wd_limit_load = 1'b0, hang = 1'b0;
  logic watchdog_restart_instruction = 1'b0, imm_read = 1'b0;
  logic [15:0] wd_limit_value = 16'h0, input_pins = 16'h0;
  logic [3:0]  imm_index = 4'h0, special_modules = 4'h2, k;
  logic [7:0]  input_points = 8'h8, special_points = 8'h4, error_code;
  logic solve_end, bus_pending, periph_connected, periph_request, periph_done, run_mode;
  logic init_done, imm_bit, periph_grant, bus_grant, scan_overrun_error, status_first_scan;
  logic [15:0] solve_outputs, input_image, output_pins, wd_limit, wd_count;
  logic [15:0] scan_cur, scan_min, scan_max, o_exp;
  logic [2:0]  segment;
  logic [31:0] v;
  int n_mismatch = 0, compares = 0, cyc = 0, seed = 99, i, pg_n = 0;
  logic q[$];
  always #10 clk_sys = ~clk_sys;
  swtm_scan_watchdog #(.INIT_MS(1)) dut (.clk_sys, .srst, .run_request, .wd_limit_load,
    .wd_limit_value, .watchdog_restart_instruction, .solve_end, .input_points,
    .special_modules, .special_points, .periph_connected, .periph_request, .periph_done,
    .bus_pending, .input_pins, .imm_read, .imm_index, .solve_outputs, .run_mode, .init_done,
    .segment, .input_image, .output_pins, .imm_bit, .periph_grant, .bus_grant, .wd_limit,
    .wd_count, .scan_cur, .scan_min, .scan_max, .scan_overrun_error, .error_code,
    .status_first_scan);
  swtm_exec_model u_exec (.clk_sys, .srst, .hang, .segment, .bus_grant, .solve_end,
    .bus_pending, .periph_connected, .periph_request, .periph_done, .solve_outputs,
    .periph_grant);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_seg(input logic [2:0] s, input int lim);
    for (i = 0; i < lim && segment !== s; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(16'(i < lim), 16'h1);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (periph_grant === 1'b1) pg_n <= pg_n + 1;
    if (cyc == 110000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1 chk(wd_limit, 16'h00c8);
    chk(scan_min, 16'hffff);
    $display("test reset values done");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys) wd_limit_load <= 1'b1;
      wd_limit_value <= j ? 16'd1 : 16'd300;
      @(posedge clk_sys) wd_limit_load <= 1'b0;
      #1 chk(wd_limit, j ? 16'd1 : 16'd300);
    end
    $display("test limit load done");
    wait_seg(3'd1, 60000);
    chk(16'(init_done), 16'h1);
    $display("test init done");
    wait_seg(3'd2, 2000);
    chk(16'(i >= (12600 + 2500 * 8) / 20 && i <= (12600 + 2500 * 8) / 20 + 2), 16'h1);
    for (int m = 0; m < 9; m++) begin
      v = $random(seed);
      k = v[19:16];
      @(posedge clk_sys) input_pins <= v[15:0];
      imm_index <= k;
      imm_read <= m < 8;
      #1 if (m > 0) chk(16'(imm_bit), 16'(q.pop_front()));
      q.push_back(v[k]);
    end
    $display("test immediate read done");
    @(posedge clk_sys) run_request <= 1'b1;
    wait_seg(3'd6, 20000);
    chk(input_image, 16'h0);
    chk(16'(status_first_scan), 16'h1);
    chk(16'(pg_n >= 8000 / 20 && pg_n <= 410000 / 20), 16'h1);
    @(posedge clk_sys) watchdog_restart_instruction <= 1'b1;
    @(posedge clk_sys) watchdog_restart_instruction <= 1'b0;
    #1 chk(wd_count, 16'h0);
    wait_seg(3'd7, 200);
    o_exp = solve_outputs;
    @(posedge clk_sys);
    #1 chk(output_pins, o_exp);
    wait_seg(3'd6, 20000);
    chk(16'(status_first_scan), 16'h0);
    chk(16'(scan_min !== 16'hffff), 16'h1);
    chk(scan_max, 16'h0);
    chk(scan_cur, 16'h0);
    chk(input_image, v[15:0]);
    $display("test run scan done");
    @(posedge clk_sys) hang <= 1'b1;
    for (i = 0; i < 60000 && scan_overrun_error !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({8'h0, error_code}, 16'h0003);
    chk(output_pins, 16'h0);
    repeat (5) @(posedge clk_sys);
    #1 chk(16'(run_mode), 16'h0);
    $display("test overrun done");
    final_report();
  end
endmodule // tb
